/* shared/fllb_pkg.sv */
// Shared constants and types for the fault-log block formatter
package fllb_pkg;

   // Block layout, indexed from 0 (bus data byte 1)
   localparam logic [7:0] IDX_FIRST      = 8'h00;
   localparam logic [7:0] IDX_HIST_FIRST = 8'h47;
   localparam logic [7:0] IDX_HIST_LAST  = 8'hED;
   localparam logic [7:0] IDX_RSV_LAST   = 8'hFE;
   localparam logic [7:0] RSV_FILL       = 8'h00;

   // Record geometry: 54 byte positions, four records stored
   localparam logic [5:0] POS_LAST       = 6'h35;
   localparam logic [5:0] POS_FIRST      = 6'h00;
   localparam logic [1:0] REC_LAST       = 2'h3;
   localparam logic [7:0] REC_LEN        = 8'h36;
   localparam int         RAM_DEPTH      = 216;
   localparam int         RAM_AW         = 8;

   // Reset values of the last-write pointer, so the first write lands at 0
   localparam logic [5:0] POS_RST        = 6'h35;
   localparam logic [1:0] REC_RST        = 2'h3;

   // Preamble body, bytes 1..70; the last field sits in the low bits
   typedef struct packed {
      logic [11:0][7:0]  status;
      logic [25:0][15:0] extreme;
      logic [6:0]        time_pad;
      logic [40:0]       shared_timebase_count;
   } fllb_preamble_s;

   // Commands from the serial engine, link clock domain, one-cycle pulses
   typedef struct packed {
      logic start;
      logic req;
      logic done;
   } fllb_cmd_s;

   // Byte returned to the serial engine
   typedef struct packed {
      logic [7:0] data;
      logic       valid;
   } fllb_reply_s;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_FETCH = 2'b01,
      ST_SEND  = 2'b11
   } fllb_state_e;

endpackage

/* hw/fllb_log_ram.sv */
// Working log buffer: one write port, registered read port
module fllb_log_ram
   import fllb_pkg::*;
(
   // Clock
   input  wire logic              ref_clk_i,
   // Write port
   input  wire logic              wr_en_i,
   input  wire logic [RAM_AW-1:0] wr_addr_i,
   input  wire logic [7:0]        wr_data_i,
   // Read port
   input  wire logic [RAM_AW-1:0] rd_addr_i,
   output logic      [7:0]        rd_data_o
);

   logic [7:0] mem [RAM_DEPTH];

   always_ff @(posedge ref_clk_i)
   begin
      if (wr_en_i)
      begin
         mem[wr_addr_i] <= wr_data_i;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      rd_data_o <= mem[rd_addr_i];
   end

endmodule // fllb_log_ram

/* hw/fllb_formatter.sv */
// Fault-log block formatter: log buffer, snapshot sequencer and link-side byte port
// Functional notes
// - History in bytes 71-237, reserved 238-254
// - Byte 71 is entry at last-write pointer
// - Each next byte one position lower
// - 71-byte preamble: pointer, time, extremes, status
// - Index 0 is bus data byte 1
// - History holds about 3.1 truncated records
// - Record position map of 54 bytes
// - Channel group byte order within record
// - Read-only 255-byte block from buffer
// - Buffer updates per sample while unlocked and no snapshot is being read out
// - Lock cleared only by successful read
module fllb_formatter
   import fllb_pkg::*;
(
   // System clock and reset
   input  wire logic                     ref_clk_i,
   input  wire logic                     sys_rst_i,
   // Measurement side, system domain
   input  wire logic                     sample_valid_i,
   input  wire logic [7:0]               sample_data_i,
   input  wire logic                     restore_done_i,
   input  wire fllb_pkg::fllb_preamble_s preamble_i,
   // Status, system domain
   output logic                          log_locked_o,
   output logic                          read_busy_o,
   // Serial engine side, link domain
   input  wire logic                     link_clk_i,
   input  wire fllb_pkg::fllb_cmd_s      link_cmd_i,
   output fllb_pkg::fllb_reply_s         reply_o
);

   fllb_state_e       state;
   logic              lock;
   logic              busy;
   logic [5:0]        lst_pos;
   logic [1:0]        lst_rec;
   logic [5:0]        next_pos;
   logic [1:0]        next_rec;
   logic [5:0]        cur_pos;
   logic [1:0]        cur_rec;
   logic [5:0]        snap_pos;
   logic [7:0]        idx;
   logic              req_pend;
   logic [7:0]        byte_hold;
   logic              ack_tgl;
   logic              wr_en;
   logic [RAM_AW-1:0] wr_addr;
   logic [RAM_AW-1:0] rd_addr;
   logic [7:0]        rd_data;
   logic [7:0]        plain_byte;
   logic              in_hist;
   logic [9:0]        bit_base;

   // Link-domain signals
   logic              lrst_meta;
   logic              lrst;
   logic              start_tgl;
   logic              req_tgl;
   logic              done_tgl;
   logic [2:0]        ack_sync;

   // System-domain synchronisers for the three command toggles
   logic [2:0]        start_sync;
   logic [2:0]        req_sync;
   logic [2:0]        done_sync;
   logic              start_evt;
   logic              req_evt;
   logic              done_evt;

   // ---------------- Measurement write side ----------------

   always_comb
   begin
      if (lst_pos == POS_LAST)
      begin
         next_pos = POS_FIRST;
         next_rec = lst_rec + 2'h1;
      end
      else
      begin
         next_pos = lst_pos + 6'h01;
         next_rec = lst_rec;
      end
   end

   // Writes are frozen while locked and while a snapshot is being read out
   assign wr_en   = sample_valid_i && !lock && !busy;
   assign wr_addr = 8'(next_rec * REC_LEN) + 8'(next_pos);

   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         lst_pos <= POS_RST;
         lst_rec <= REC_RST;
      end
      else if (wr_en)
      begin
         lst_pos <= next_pos;
         lst_rec <= next_rec;
      end
   end

   // Lock set after a restore; a restore in the same cycle as a finished read wins
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         lock <= 1'b0;
      end
      else if (restore_done_i)
      begin
         lock <= 1'b1;
      end
      else if (done_evt && busy)
      begin
         lock <= 1'b0;
      end
   end

   fllb_log_ram u_ram (
      .ref_clk_i (ref_clk_i),
      .wr_en_i   (wr_en),
      .wr_addr_i (wr_addr),
      .wr_data_i (sample_data_i),
      .rd_addr_i (rd_addr),
      .rd_data_o (rd_data)
   );

   // ---------------- Command crossing into the system domain ----------------

   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         start_sync <= 3'h0;
         req_sync   <= 3'h0;
         done_sync  <= 3'h0;
      end
      else
      begin
         start_sync <= {start_sync[1:0], start_tgl};
         req_sync   <= {req_sync[1:0], req_tgl};
         done_sync  <= {done_sync[1:0], done_tgl};
      end
   end

   assign start_evt = start_sync[2] ^ start_sync[1];
   assign req_evt   = req_sync[2] ^ req_sync[1];
   assign done_evt  = done_sync[2] ^ done_sync[1];

   // Pending request; a new request wins over the clear when both meet
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         req_pend <= 1'b0;
      end
      else if (req_evt)
      begin
         req_pend <= 1'b1;
      end
      else if (state == ST_SEND || start_evt)
      begin
         req_pend <= 1'b0;
      end
   end

   // ---------------- Byte selection ----------------

   assign in_hist  = (idx >= IDX_HIST_FIRST) && (idx <= IDX_HIST_LAST);
   assign rd_addr  = 8'(cur_rec * REC_LEN) + 8'(cur_pos);
   assign bit_base = 10'({idx - 8'h01, 3'b000});

   always_comb
   begin
      if (idx == IDX_FIRST)
      begin
         plain_byte = {2'b00, snap_pos};
      end
      else if (idx < IDX_HIST_FIRST)
      begin
         plain_byte = preamble_i[bit_base +: 8];
      end
      else
      begin
         plain_byte = RSV_FILL;
      end
   end

   // ---------------- Snapshot sequencer ----------------

   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         state    <= ST_IDLE;
         busy     <= 1'b0;
         idx      <= IDX_FIRST;
         cur_pos  <= POS_RST;
         cur_rec  <= REC_RST;
         snap_pos <= POS_RST;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               if (start_evt)
               begin
                  busy     <= 1'b1;
                  idx      <= IDX_FIRST;
                  cur_pos  <= lst_pos;
                  cur_rec  <= lst_rec;
                  snap_pos <= lst_pos;
               end
               else if (done_evt)
               begin
                  busy <= 1'b0;
               end
               else if (req_pend && busy)
               begin
                  state <= in_hist ? ST_FETCH : ST_SEND;
               end
            end
            ST_FETCH:
            begin
               if (cur_pos == POS_FIRST)
               begin
                  cur_pos <= POS_LAST;
                  cur_rec <= cur_rec - 2'h1;
               end
               else
               begin
                  cur_pos <= cur_pos - 6'h01;
               end
               state <= ST_SEND;
            end
            ST_SEND:
            begin
               if (idx != 8'hFF)
               begin
                  idx <= idx + 8'h01;
               end
               state <= ST_IDLE;
            end
            default:
            begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Byte handed to the link domain; held stable until the next request loads it
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         byte_hold <= RSV_FILL;
      end
      else if (state == ST_FETCH)
      begin
         byte_hold <= rd_data;
      end
      else if (state == ST_IDLE && req_pend && busy && !start_evt && !done_evt && !in_hist)
      begin
         byte_hold <= (idx > IDX_RSV_LAST) ? RSV_FILL : plain_byte;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         ack_tgl <= 1'b0;
      end
      else if (state == ST_SEND)
      begin
         ack_tgl <= ~ack_tgl;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         log_locked_o <= 1'b0;
         read_busy_o  <= 1'b0;
      end
      else
      begin
         log_locked_o <= lock;
         read_busy_o  <= busy;
      end
   end

   // ---------------- Link domain ----------------

   always_ff @(posedge link_clk_i)
   begin
      lrst_meta <= sys_rst_i;
      lrst      <= lrst_meta;
   end

   always_ff @(posedge link_clk_i)
   begin
      if (lrst)
      begin
         start_tgl <= 1'b0;
         req_tgl   <= 1'b0;
         done_tgl  <= 1'b0;
      end
      else
      begin
         start_tgl <= start_tgl ^ link_cmd_i.start;
         req_tgl   <= req_tgl ^ link_cmd_i.req;
         done_tgl  <= done_tgl ^ link_cmd_i.done;
      end
   end

   always_ff @(posedge link_clk_i)
   begin
      if (lrst)
      begin
         ack_sync <= 3'h0;
      end
      else
      begin
         ack_sync <= {ack_sync[1:0], ack_tgl};
      end
   end

   // byte_hold is stable for the whole crossing of its toggle
   always_ff @(posedge link_clk_i)
   begin
      if (lrst)
      begin
         reply_o <= '0;
      end
      else
      begin
         reply_o.valid <= ack_sync[2] ^ ack_sync[1];
         if (ack_sync[2] ^ ack_sync[1])
         begin
            reply_o.data <= byte_hold;
         end
      end
   end

endmodule // fllb_formatter

/* verif/fllb_formatter_sva.sv */
// Port assertions for the fault-log block formatter
module fllb_formatter_sva
   import fllb_pkg::*;
(
   // System domain
   input wire logic                  ref_clk_i,
   input wire logic                  sys_rst_i,
   input wire logic                  restore_done_i,
   input wire logic                  log_locked_o,
   input wire logic                  read_busy_o,
   // Link domain
   input wire logic                  link_clk_i,
   input wire fllb_pkg::fllb_cmd_s   link_cmd_i,
   input wire fllb_pkg::fllb_reply_s reply_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic active;
   logic pend;

   always_ff @(posedge link_clk_i)
   begin
      if (sys_rst_i || link_cmd_i.done)
         active <= 1'b0;
      else if (link_cmd_i.start)
         active <= 1'b1;
   end

   always_ff @(posedge link_clk_i)
   begin
      if (sys_rst_i || reply_o.valid)
         pend <= 1'b0;
      else if (link_cmd_i.req && active)
         pend <= 1'b1;
   end

   sequence s_restore;
      restore_done_i;
   endsequence

   sequence s_lock_late;
      ##2 log_locked_o;
   endsequence

   chk_lock_set: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      s_restore |-> s_lock_late) else $error("lock late");
   chk_lock_clear: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      $fell(log_locked_o) |-> $past(read_busy_o) || $past(read_busy_o, 2) || $past(read_busy_o, 3))
      else $error("lock cleared without read");
   chk_lock_quiet: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      !log_locked_o && !restore_done_i && !$past(restore_done_i) |=> !log_locked_o) else $error("lock rose");
   chk_reset_idle: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      $fell(sys_rst_i) |-> !log_locked_o && !read_busy_o) else $error("flags after reset");
   chk_valid_pulse: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
      reply_o.valid |=> !reply_o.valid) else $error("valid too long");
   chk_data_hold: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
      !reply_o.valid && !$past(sys_rst_i, 2) |-> $stable(reply_o.data)) else $error("data moved");
   chk_req_reply: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
      link_cmd_i.req && active && !pend |-> ##[1:12] reply_o.valid) else $error("no reply");
   chk_no_stray: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
      reply_o.valid |-> pend) else $error("stray reply");
endmodule // fllb_formatter_sva

/* verif/fllb_host_model.sv */
// Serial engine model: block-read commands and reply collection
module fllb_host_model
   import fllb_pkg::*;
(
   // Link side
   input  wire logic                  link_clk_i,
   input  wire fllb_pkg::fllb_reply_s reply_i,
   output fllb_pkg::fllb_cmd_s        cmd_o
);
   timeunit 1ns;
   timeprecision 1ps;

   initial cmd_o = '0;

   // One-cycle pulse: 0 start, 1 req, 2 done
   task automatic pulse(input int k);
      @(posedge link_clk_i);
      #1;
      cmd_o = fllb_cmd_s'(3'b100 >> k);
      @(posedge link_clk_i);
      #1;
      cmd_o = '0;
   endtask

   // Answer n is bus data byte n+1
   task automatic get(output logic [7:0] d, output bit ok);
      ok = 1'b0;
      d = 8'h00;
      pulse(1);
      for (int n = 0; n < 12 && !ok; n++)
      begin
         @(posedge link_clk_i);
         ok = reply_i.valid === 1'b1;
         d = reply_i.data;
      end
   endtask
endmodule // fllb_host_model

/* verif/fllb_formatter_tb_top.sv */
// Testbench: random logging, restore lock and full block reads
module fllb_formatter_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import fllb_pkg::*;

   logic           ref_clk_i = 1'b0;
   logic           link_clk_i = 1'b0;
   logic           sys_rst_i = 1'b1;
   logic           sample_valid_i = 1'b0;
   logic [7:0]     sample_data_i = 8'h00;
   logic           restore_done_i = 1'b0;
   fllb_preamble_s preamble_i = '0;
   logic           log_locked_o;
   logic           read_busy_o;
   fllb_cmd_s      link_cmd_i;
   fllb_reply_s    reply_o;
   logic [7:0]     mem [216];
   int             pos = 53;
   int             rec = 3;
   integer         seed = 32'h97EB7DE6;
   int             err_count = 0;
   int             comparisons = 0;
   bit             lock_m = 1'b0;

   always #10 ref_clk_i = ~ref_clk_i;
   always #24 link_clk_i = ~link_clk_i;

   fllb_formatter uut (.ref_clk_i, .sys_rst_i, .sample_valid_i, .sample_data_i, .restore_done_i,
                       .preamble_i, .log_locked_o, .read_busy_o, .link_clk_i, .link_cmd_i, .reply_o);
   fllb_host_model host (.link_clk_i, .reply_i(reply_o), .cmd_o(link_cmd_i));

   task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask

   task automatic conclude();
      $display("compares %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Mirror follows the ring only while unlocked
   task automatic feed(input int n);
      repeat (n)
      begin
         @(posedge ref_clk_i);
         #1;
         sample_valid_i = 1'b1;
         sample_data_i = 8'($random(seed));
         if (!lock_m)
         begin
            pos = (pos + 1) % 54;
            rec = (pos == 0) ? (rec + 1) % 4 : rec;
            mem[rec * 54 + pos] = sample_data_i;
         end
      end
      @(posedge ref_clk_i);
      #1;
      sample_valid_i = 1'b0;
   endtask

   function automatic logic [7:0] expect_byte(input int i);
      int p;
      int r;
      p = pos - (i - 71);
      r = rec;
      if (i == 0)
         return 8'(pos);
      if (i < 71)
         return preamble_i[(i - 1) * 8 +: 8];
      if (i > 237)
         return RSV_FILL;
      while (p < 0)
      begin
         p += 54;
         r = (r + 3) % 4;
      end
      return mem[r * 54 + p];
   endfunction

   // All 255 bytes plus one past the end
   task automatic read_block();
      logic [7:0] d;
      bit         ok;
      host.pulse(0);
      repeat (5) @(posedge link_clk_i);
      cmp("read_busy_o", 8'h01, 8'(read_busy_o));
      for (int i = 0; i < 256; i++)
      begin
         host.get(d, ok);
         if (!ok)
         begin
            err_count++;
            $display("BAD reply_o.valid exp 1 got 0");
            conclude();
         end
         cmp("block byte", expect_byte(i), d);
      end
      host.pulse(2);
   endtask

   initial
   begin
      repeat (5) @(posedge ref_clk_i);
      #1;
      sys_rst_i = 1'b0;
      repeat (8) @(posedge link_clk_i);
      for (int k = 0; k < 3; k++)
      begin
         for (int j = 0; j < 560; j += 16)
            preamble_i[j +: 16] = 16'($random(seed));
         if (k == 1)
         begin
            @(posedge ref_clk_i);
            #1;
            restore_done_i = 1'b1;
            @(posedge ref_clk_i);
            #1;
            restore_done_i = 1'b0;
            lock_m = 1'b1;
            host.pulse(2);
            repeat (10) @(posedge ref_clk_i);
            cmp("log_locked_o", 8'h01, 8'(log_locked_o));
         end
         feed(k == 0 ? 230 : 40 + ($random(seed) & 63));
         read_block();
         repeat (10) @(posedge ref_clk_i);
         lock_m = 1'b0;
         cmp("log_locked_o", 8'h00, 8'(log_locked_o));
         cmp("read_busy_o", 8'h00, 8'(read_busy_o));
      end
      conclude();
   end
endmodule // fllb_formatter_tb_top

bind fllb_formatter fllb_formatter_sva chk (.ref_clk_i, .sys_rst_i, .restore_done_i, .log_locked_o,
                                            .read_busy_o, .link_clk_i, .link_cmd_i, .reply_o);
